// File: test/irq_ctrl_sva.sv
`timescale 1ns/1ps
module irq_ctrl_sva
  import irq_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // CPU side
  input wire logic irqRequest,
  input wire logic [VEC_W-1:0] irqVector,
  input wire logic [23:0] handlerAddr
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  wire logic setup = psel && !penable;
  //////////////////////////////
  AST_ZERO_WAIT: assert property (setup |=> pready && psel && penable)
    else $error("pready did not follow setup");
  AST_ONE_PULSE: assert property (pready |=> !pready)
    else $error("pready held two cycles");
  AST_IDLE_QUIET: assert property (!psel |=> !pready)
    else $error("pready without a transfer");
  AST_UNMAPPED: assert property (setup && paddr[11:2] > 10'h034 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (setup && paddr[11:2] <= 10'h034 |=> !pslverr)
    else $error("mapped access refused");
  AST_UPPER_ZERO: assert property (pready |-> prdata[31:16] == 16'h0)
    else $error("upper read half not zero");
  AST_SLOT: assert property (irqRequest |-> handlerAddr[7:0] == 8'h04 + {irqVector, 1'b0} && handlerAddr[23:9] == 15'h0)
    else $error("handler slot does not match vector");
  AST_VEC_LEGAL: assert property (irqRequest |-> irqVector inside {[7'd1:7'd4], [7'd8:7'd79]})
    else $error("reserved vector taken");
  AST_VEC_HOLD: assert property (!irqRequest |-> $stable(irqVector) && $stable(handlerAddr))
    else $error("vector moved without accept");
endmodule : irq_ctrl_sva

bind vectored_priority_interrupt_ctrl irq_ctrl_sva i_sva (.clk_sys, .resetn, .psel, .penable, .paddr,
  .prdata, .pready, .pslverr, .irqRequest, .irqVector, .handlerAddr);

// File: test/irq_source_model.sv
`timescale 1ns/1ps
module irq_source_model
  import irq_ctrl_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Requests
  output logic [NUM_REQ-1:0] periphReq,
  output logic [NUM_EXT-1:0] extPin,
  output logic trapMathErr
);
  initial
  begin
    periphReq = '0;
    extPin = '0;
    trapMathErr = 1'b0;
  end
  // External requests arrive on their pins, all others on periphReq
  task automatic hit(input int r);
    if (r == int'(EXT0_REQ))
      extPin[0] <= 1'b1;
    else if (r == int'(EXT1_REQ))
      extPin[1] <= 1'b1;
    else if (r == int'(EXT2_REQ))
      extPin[2] <= 1'b1;
    else
      periphReq[r] <= 1'b1;
  endtask : hit
  task automatic pulse(input int a, input int b);
    @(posedge clk_sys);
    hit(a);
    if (b != a)
      hit(b);
    @(posedge clk_sys);
    periphReq <= '0;
    extPin <= '0;
  endtask : pulse
  // Math fault level
  task automatic raise(input logic v);
    @(posedge clk_sys);
    trapMathErr <= v;
  endtask : raise
endmodule : irq_source_model

// File: test/vectored_priority_interrupt_ctrl_tb_top.sv
`timescale 1ns/1ps
module vectored_priority_interrupt_ctrl_tb_top
  import irq_ctrl_pkg::*;
;
  logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, irqRequest;
  logic repeatActive, trapMathErr, err;
  logic trapOscFail, trapAddrErr, trapStackErr, trapDivZero;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NUM_REQ-1:0] periphReq;
  logic [NUM_EXT-1:0] extPin;
  logic [VEC_W-1:0] irqVector;
  logic [23:0] handlerAddr;
  int mismatches, tests_run, cycles, seed, i, a, b, lvl, saved;
  int prio[NUM_REQ];
  bit en[NUM_REQ];
  bit flg[NUM_REQ];
  bit alt;

  vectored_priority_interrupt_ctrl i_dut (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .periphReq, .extPin, .trapOscFail, .trapAddrErr,
    .trapStackErr, .trapMathErr, .trapDivZero, .repeatActive, .irqRequest, .irqVector,
    .handlerAddr);
  irq_source_model i_src (.clk_sys, .periphReq, .extPin, .trapMathErr);

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      final_report();
    end
  end
  //////////////////////////////
  task automatic final_report();
    if (mismatches == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [11:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    check(rd, exp);
  endtask : rdchk

  task automatic cfg(input int r, input int p, input bit e);
    logic [31:0] ew;
    logic [31:0] pw;
    int j;
    prio[r] = p;
    en[r] = e;
    ew = '0;
    pw = '0;
    for (j = 0; j < 16; j++)
    begin
      if (r / 16 * 16 + j < NUM_REQ) ew[j] = en[r / 16 * 16 + j];
      if (j < 4 && r / 4 * 4 + j < NUM_REQ) pw[4 * j +: 3] = 3'(prio[r / 4 * 4 + j]);
    end
    apb(1'b1, 12'(ENABLE_BASE_OFFSET + 4 * (r / 16)), ew);
    apb(1'b1, 12'(PRIO_BASE_OFFSET + 4 * (r / 4)), pw);
  endtask : cfg

  function automatic int winner();
    int r;
    int w;
    w = -1;
    for (r = 0; r < int'(RESERVED_REQ_FIRST); r++)
      if (flg[r] && en[r] && prio[r] > lvl && (w < 0 || prio[r] > prio[w])) w = r;
    return w;
  endfunction : winner

  task automatic take(input int v);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (irqRequest !== 1'b1 && n < 12);
    check(irqRequest, v >= 0);
    if (v >= 0)
    begin
      check(irqVector, v);
      check(handlerAddr, (alt ? ALT_TABLE_BASE : DEFAULT_TABLE_BASE) + 24'(2 * v));
      if (v == 73)
        check(handlerAddr, alt ? UART_ERR_ALT_SLOT : UART_ERR_DEFAULT_SLOT);
    end
  endtask : take

  task automatic step();
    int w;
    w = winner();
    take(w < 0 ? -1 : w + 8);
    if (w >= 0)
    begin
      flg[w] = 0;
      saved = lvl;
      lvl = prio[w];
      rdchk(PENDING_OFFSET, lvl * 128 + w + 8);
      rdchk(STATUS_WORD_OFFSET, lvl * 32);
    end
  endtask : step

  task automatic ret();
    apb(1'b1, RETURN_OFFSET, 32'h0);
    lvl = saved;
  endtask : ret
  //////////////////////////////
  initial
  begin
    seed = 37;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {trapOscFail, trapAddrErr, trapStackErr, trapDivZero} = '0;
    repeatActive = 1'b0;
    resetn = 1'b0;
    for (i = 0; i < NUM_REQ; i++) prio[i] = 4;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    rdchk(STATUS_WORD_OFFSET, 32'h0);
    rdchk(CTRL_A_OFFSET, 32'h0);
    rdchk(CORE_CTRL_OFFSET, 32'h0);
    rdchk(PRIO_BASE_OFFSET, 32'h4444);
    apb(1'b0, 12'h0d4, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    repeatActive <= 1'b1;
    apb(1'b1, STATUS_WORD_OFFSET, 32'hffff);
    rdchk(STATUS_WORD_OFFSET, 32'h1ff);
    lvl = 7;
    cfg(3, 7, 1'b1);
    i_src.pulse(3, 3);
    flg[3] = 1;
    step();
    rdchk(FLAG_BASE_OFFSET, 32'h8);
    apb(1'b1, CTRL_A_OFFSET, 32'h8000);
    apb(1'b1, STATUS_WORD_OFFSET, 32'h0);
    rdchk(STATUS_WORD_OFFSET, 32'hf0);
    repeatActive <= 1'b0;
    apb(1'b1, CTRL_A_OFFSET, 32'h0);
    apb(1'b1, STATUS_WORD_OFFSET, 32'h0);
    lvl = 0;
    step();
    ret();
    apb(1'b1, CTRL_A_OFFSET, 32'h8000);
    cfg(5, 3, 1'b1);
    cfg(6, 6, 1'b1);
    i_src.pulse(5, 5);
    flg[5] = 1;
    step();
    i_src.pulse(6, 6);
    flg[6] = 1;
    take(-1);
    ret();
    step();
    ret();
    apb(1'b1, CTRL_A_OFFSET, 32'h0);
    for (i = 0; i < 12; i++)
    begin
      alt = i[0];
      apb(1'b1, CTRL_B_OFFSET, {16'h0, alt, 15'h0});
      a = i == 0 ? int'(UART_ERR_REQ) : {$random(seed)} % 72;
      b = {$random(seed)} % 72;
      cfg(a, 1 + {$random(seed)} % 7, 1'b1);
      cfg(b, 1 + {$random(seed)} % 7, i != 3);
      i_src.pulse(a, b);
      flg[a] = 1;
      flg[b] = 1;
      repeat (2)
      begin
        step();
        if (lvl > 0) ret();
      end
      rdchk(12'(FLAG_BASE_OFFSET + 4 * (b / 16)), 32'(flg[b]) << (b % 16));
      apb(1'b1, 12'(FLAG_BASE_OFFSET + 4 * (b / 16)), 32'h0);
      flg[b] = 0;
    end
    apb(1'b1, CTRL_B_OFFSET, 32'h1);
    alt = 0;
    rdchk(CTRL_B_OFFSET, 32'h1);
    cfg(0, 5, 1'b1);
    i_src.pulse(0, 0);
    flg[0] = 1;
    step();
    ret();
    cfg(80, 7, 1'b1);
    i_src.pulse(80, 80);
    take(-1);
    saved = lvl;
    trapDivZero <= 1'b1;
    i_src.raise(1'b1);
    take(int'(TRAP_VEC_MATH));
    rdchk(CORE_CTRL_OFFSET, 32'h8);
    rdchk(STATUS_WORD_OFFSET, 32'h60);
    rdchk(CTRL_A_OFFSET, 32'h50);
    trapAddrErr <= 1'b1;
    take(int'(TRAP_VEC_ADDR));
    trapAddrErr <= 1'b0;
    trapDivZero <= 1'b0;
    rdchk(STATUS_WORD_OFFSET, 32'ha0);
    i_src.raise(1'b0);
    apb(1'b1, CORE_CTRL_OFFSET, 32'h0);
    rdchk(CORE_CTRL_OFFSET, 32'h8);
    apb(1'b1, CTRL_A_OFFSET, 32'h0);
    ret();
    rdchk(CORE_CTRL_OFFSET, 32'h0);
    final_report();
  end
endmodule : vectored_priority_interrupt_ctrl_tb_top

// File: verilog/ext_edge_detect.sv
`timescale 1ns/1ps

module ext_edge_detect
  import irq_ctrl_pkg::*;
#(
  parameter int WIDTH = 3
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Pins and polarity
  input wire logic [WIDTH-1:0] pinLevel,
  input wire logic [WIDTH-1:0] negEdgeSel,
  // Detected edges
  output logic [WIDTH-1:0] edgeSeen
);

  logic [WIDTH-1:0] lastLevel_reg;
  logic [WIDTH-1:0] lastLevel_next;
  // Blocks a false edge on the first edge after reset when a pin idles high
  logic primed_reg;
  logic primed_next;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("WIDTH must be at least 1");
    end
  end

  always_comb
  begin
    lastLevel_next = pinLevel;
    primed_next = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      lastLevel_reg <= '0;
      primed_reg <= 1'b0;
    end
    else
    begin
      lastLevel_reg <= lastLevel_next;
      primed_reg <= primed_next;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : gEdge
      assign edgeSeen[i] = primed_reg & (negEdgeSel[i] ? (lastLevel_reg[i] & ~pinLevel[i])
                                                       : (~lastLevel_reg[i] & pinLevel[i]));
    end
  endgenerate

endmodule : ext_edge_detect

// File: verilog/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

  // Source and register geometry
  localparam int NUM_REQ = 118;
  localparam int NUM_WORDS = 8;
  localparam int PRIO_WORDS = 30;
  localparam int REQ_PER_PRIO = 4;
  localparam int PRIO_W = 3;
  localparam int LEVEL_W = 4;
  localparam int VEC_W = 7;
  localparam int REQ_W = 7;

  // Vector numbering
  localparam logic [6:0] USER_VEC_BASE = 7'h08;
  localparam logic [6:0] UART_ERR_REQ = 7'h41;
  localparam logic [6:0] RESERVED_REQ_FIRST = 7'h48;
  localparam logic [6:0] TRAP_VEC_OSC = 7'h01;
  localparam logic [6:0] TRAP_VEC_ADDR = 7'h02;
  localparam logic [6:0] TRAP_VEC_STACK = 7'h03;
  localparam logic [6:0] TRAP_VEC_MATH = 7'h04;
  localparam logic [3:0] TRAP_LEVEL_OSC = 4'he;
  localparam logic [3:0] TRAP_LEVEL_ADDR = 4'hd;
  localparam logic [3:0] TRAP_LEVEL_STACK = 4'hc;
  localparam logic [3:0] TRAP_LEVEL_MATH = 4'hb;

  // Handler tables: slot = base + 2 * vector
  localparam logic [23:0] DEFAULT_TABLE_BASE = 24'h000004;
  localparam logic [23:0] ALT_TABLE_BASE = 24'h000104;
  localparam logic [23:0] UART_ERR_DEFAULT_SLOT = 24'h000096;
  localparam logic [23:0] UART_ERR_ALT_SLOT = 24'h000196;

  // Register byte offsets (32-bit APB words)
  localparam logic [11:0] CTRL_A_OFFSET = 12'h000;
  localparam logic [11:0] CTRL_B_OFFSET = 12'h004;
  localparam logic [11:0] FLAG_BASE_OFFSET = 12'h008;
  localparam logic [11:0] ENABLE_BASE_OFFSET = 12'h028;
  localparam logic [11:0] PRIO_BASE_OFFSET = 12'h048;
  localparam logic [11:0] PENDING_OFFSET = 12'h0c0;
  localparam logic [11:0] STATUS_WORD_OFFSET = 12'h0c4;
  localparam logic [11:0] CORE_CTRL_OFFSET = 12'h0c8;
  localparam logic [11:0] ACK_OFFSET = 12'h0cc;
  localparam logic [11:0] RETURN_OFFSET = 12'h0d0;

  // Field positions
  localparam int NEST_DIS_BIT = 15;
  localparam int TRAP_OSC_BIT = 1;
  localparam int TRAP_STACK_BIT = 2;
  localparam int TRAP_ADDR_BIT = 3;
  localparam int TRAP_MATH_BIT = 4;
  localparam int TRAP_DIV0_BIT = 6;
  localparam int ALT_SEL_BIT = 15;
  localparam int EDGE_POL_LSB = 0;
  localparam int NUM_EXT = 3;
  localparam int LEVEL_LSB = 5;
  localparam int REPEAT_BIT = 4;
  localparam int TOP_LEVEL_BIT = 3;
  localparam logic [15:0] STATUS_WR_MASK = 16'h010f;
  localparam logic [15:0] CTRL_A_MASK = 16'h805e;
  localparam logic [15:0] CTRL_B_MASK = 16'h8007;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [2:0] PRIO_RESET = 3'h4;

  // External request pins sit at these request numbers
  localparam logic [6:0] EXT0_REQ = 7'h00;
  localparam logic [6:0] EXT1_REQ = 7'h14;
  localparam logic [6:0] EXT2_REQ = 7'h1d;

endpackage : irq_ctrl_pkg

// File: verilog/prio_arbiter.sv
`timescale 1ns/1ps

module prio_arbiter
  import irq_ctrl_pkg::*;
#(
  parameter int N = 118
)
(
  // Requests
  input wire logic [N-1:0] active,
  input wire logic [N*PRIO_W-1:0] prio,
  // Winner
  output logic found,
  output logic [REQ_W-1:0] winReq,
  output logic [PRIO_W-1:0] winPrio
);

  initial
  begin
    if (N < 1 || N > 128)
    begin
      $error("N out of range");
    end
  end

  // Highest priority wins, lowest request number breaks ties
  always_comb
  begin
    found = 1'b0;
    winReq = '0;
    winPrio = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (active[i] && (!found || prio[i*PRIO_W +: PRIO_W] >= winPrio))
      begin
        found = 1'b1;
        winReq = REQ_W'(i);
        winPrio = prio[i*PRIO_W +: PRIO_W];
      end
    end
  end

endmodule : prio_arbiter

// File: verilog/vectored_priority_interrupt_ctrl.sv
// Behaviour
// RULE1: UART error is request 65, vector 73
// RULE2: Traps vectors 1-4: osc, address, stack, math
// RULE3: Seventeen interrupt registers visible to software; the code decodes 53
// RULE4: Control A: nesting disable plus trap flags
// RULE5: Control B: external edge polarity, alternate table
// RULE6: Flags set by hardware, cleared by software; the code also clears a flag when its interrupt is taken
// RULE7: Per-source enable gates each request
// RULE8: Three-bit priority per user source
// RULE9: Latch vector number and new level
// RULE10: Bits allocated in ascending request order
// RULE11: Status bits 7:5 hold low level bits
// RULE12: Top level bit read-only to software
// RULE13: Level 7 blocks all user interrupts
// RULE14: Top bit set gives levels 8-15
// RULE15: Nesting disabled makes level field read-only
// RULE16: Status word flag bits, reset zero
// RULE17: Alternate select picks alternate handler table
// RULE18: Nesting disable stops nested interrupts
// RULE19: Top bit reads one when level above 7
// RULE20: Highest priority wins, above CPU level
// RULE21: Entry raises level; traps above seven
`timescale 1ns/1ps

module vectored_priority_interrupt_ctrl
  import irq_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sources
  input wire logic [NUM_REQ-1:0] periphReq,
  input wire logic [NUM_EXT-1:0] extPin,
  input wire logic trapOscFail,
  input wire logic trapAddrErr,
  input wire logic trapStackErr,
  input wire logic trapMathErr,
  input wire logic trapDivZero,
  input wire logic repeatActive,
  // CPU side
  output logic irqRequest,
  output logic [VEC_W-1:0] irqVector,
  output logic [23:0] handlerAddr
);

  ////////////////////////////////////////////////////////////////
  logic [15:0] ctrlA_reg, ctrlA_next;
  logic [15:0] ctrlB_reg, ctrlB_next;
  logic [NUM_REQ-1:0] flag_reg, flag_next;
  logic [NUM_REQ-1:0] enable_reg, enable_next;
  logic [NUM_REQ*PRIO_W-1:0] prio_reg, prio_next;
  logic [15:0] status_reg, status_next;
  logic topBit_reg, topBit_next;
  logic [15:0] pending_reg, pending_next;
  logic [LEVEL_W-1:0] savedLevel_reg, savedLevel_next;
  logic inHandler_reg, inHandler_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic irqRequest_reg, irqRequest_next;
  logic [VEC_W-1:0] irqVector_reg, irqVector_next;
  logic [23:0] handlerAddr_reg, handlerAddr_next;

  logic [NUM_EXT-1:0] extEdge;
  logic [NUM_REQ-1:0] reqActive;
  logic userFound;
  logic [REQ_W-1:0] userReq;
  logic [PRIO_W-1:0] userPrio;
  logic [LEVEL_W-1:0] cpuLevel;
  logic [NUM_REQ-1:0] hwSet;
  logic wrAccess, rdAccess;
  logic [11:0] regOff;

  ////////////////////////////////////////////////////////////////
  // RULE5: edge polarity select
  ext_edge_detect #(.WIDTH(NUM_EXT)) uEdge
  (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pinLevel(extPin),
    .negEdgeSel(ctrlB_reg[EDGE_POL_LSB +: NUM_EXT]),
    .edgeSeen(extEdge)
  );

  always_comb
  begin
    hwSet = periphReq;
    hwSet[EXT0_REQ] = extEdge[0];
    hwSet[EXT1_REQ] = extEdge[1];
    hwSet[EXT2_REQ] = extEdge[2];
    // RULE1: reserved requests never raise
    for (int i = 0; i < NUM_REQ; i++)
    begin
      if (i >= int'(RESERVED_REQ_FIRST))
        hwSet[i] = 1'b0;
    end
  end

  // RULE7: enable gates request
  assign reqActive = flag_reg & enable_reg;

  // RULE20: priority arbitration
  prio_arbiter #(.N(NUM_REQ)) uArb
  (
    .active(reqActive),
    .prio(prio_reg),
    .found(userFound),
    .winReq(userReq),
    .winPrio(userPrio)
  );

  // RULE14: full level is top bit over field
  assign cpuLevel = {topBit_reg, status_reg[LEVEL_LSB +: PRIO_W]};

  assign wrAccess = psel && penable && pwrite;
  assign rdAccess = psel && !penable && !pwrite;
  assign regOff = {paddr[11:2], 2'b00};

  ////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic [LEVEL_W-1:0] newLevel;
    logic [VEC_W-1:0] newVec;
    logic take;
    logic [15:0] wd;
    newLevel = '0;
    newVec = '0;
    take = 1'b0;
    wd = pwdata[15:0];
    ctrlA_next = ctrlA_reg;
    ctrlB_next = ctrlB_reg;
    flag_next = flag_reg;
    enable_next = enable_reg;
    prio_next = prio_reg;
    status_next = status_reg;
    topBit_next = topBit_reg;
    pending_next = pending_reg;
    savedLevel_next = savedLevel_reg;
    inHandler_next = inHandler_reg;
    irqRequest_next = 1'b0;
    irqVector_next = irqVector_reg;
    handlerAddr_next = handlerAddr_reg;
    // RULE16: repeat flag follows the core
    status_next[REPEAT_BIT] = repeatActive;

    // Software writes
    if (wrAccess)
    begin
      // RULE4: control A layout
      if (regOff == CTRL_A_OFFSET)
        ctrlA_next = wd & CTRL_A_MASK;
      // RULE5: control B layout
      if (regOff == CTRL_B_OFFSET)
        ctrlB_next = wd & CTRL_B_MASK;
      if (regOff == STATUS_WORD_OFFSET)
      begin
        // RULE16: writable flag bits
        status_next = (status_reg & ~STATUS_WR_MASK) | (wd & STATUS_WR_MASK);
        status_next[REPEAT_BIT] = repeatActive;
        // RULE11: level field writable
        // RULE15: unless nesting disabled
        if (!ctrlA_reg[NEST_DIS_BIT])
          status_next[LEVEL_LSB +: PRIO_W] = wd[LEVEL_LSB +: PRIO_W];
      end
      // RULE10: ascending request order
      for (int w = 0; w < NUM_WORDS; w++)
      begin
        if (regOff == FLAG_BASE_OFFSET + 12'(4 * w))
          for (int b = 0; b < 16; b++)
            if (16 * w + b < NUM_REQ)
              flag_next[16 * w + b] = wd[b];
        if (regOff == ENABLE_BASE_OFFSET + 12'(4 * w))
          for (int b = 0; b < 16; b++)
            if (16 * w + b < NUM_REQ)
              enable_next[16 * w + b] = wd[b];
      end
      // RULE8: three-bit fields, four per word
      for (int w = 0; w < PRIO_WORDS; w++)
      begin
        if (regOff == PRIO_BASE_OFFSET + 12'(4 * w))
          for (int s = 0; s < REQ_PER_PRIO; s++)
            if (REQ_PER_PRIO * w + s < NUM_REQ)
              prio_next[(REQ_PER_PRIO * w + s) * PRIO_W +: PRIO_W] = wd[4 * s +: PRIO_W];
      end
      // Handler return restores the saved level
      if (regOff == RETURN_OFFSET && inHandler_reg)
      begin
        topBit_next = savedLevel_reg[TOP_LEVEL_BIT];
        status_next[LEVEL_LSB +: PRIO_W] = savedLevel_reg[PRIO_W-1:0];
        inHandler_next = 1'b0;
      end
    end

    // RULE6: hardware set wins over clear
    flag_next = flag_next | hwSet;
    // RULE4: trap flags are sticky
    if (trapOscFail)
      ctrlA_next[TRAP_OSC_BIT] = 1'b1;
    if (trapAddrErr)
      ctrlA_next[TRAP_ADDR_BIT] = 1'b1;
    if (trapStackErr)
      ctrlA_next[TRAP_STACK_BIT] = 1'b1;
    if (trapMathErr)
      ctrlA_next[TRAP_MATH_BIT] = 1'b1;
    if (trapMathErr && trapDivZero)
      ctrlA_next[TRAP_DIV0_BIT] = 1'b1;

    // RULE2: fixed trap order
    if (trapOscFail && cpuLevel < TRAP_LEVEL_OSC)
    begin
      take = 1'b1;
      newVec = TRAP_VEC_OSC;
      newLevel = TRAP_LEVEL_OSC;
    end
    else if (trapAddrErr && cpuLevel < TRAP_LEVEL_ADDR)
    begin
      take = 1'b1;
      newVec = TRAP_VEC_ADDR;
      newLevel = TRAP_LEVEL_ADDR;
    end
    else if (trapStackErr && cpuLevel < TRAP_LEVEL_STACK)
    begin
      take = 1'b1;
      newVec = TRAP_VEC_STACK;
      newLevel = TRAP_LEVEL_STACK;
    end
    else if (trapMathErr && cpuLevel < TRAP_LEVEL_MATH)
    begin
      take = 1'b1;
      newVec = TRAP_VEC_MATH;
      newLevel = TRAP_LEVEL_MATH;
    end
    // RULE13: level 7 and RULE20 level compare
    // RULE18: no nesting while disabled
    else if (userFound && !topBit_reg && {1'b0, userPrio} > cpuLevel
             && !(ctrlA_reg[NEST_DIS_BIT] && inHandler_reg))
    begin
      take = 1'b1;
      // RULE1: vector is request plus eight
      newVec = userReq + USER_VEC_BASE;
      newLevel = {1'b0, userPrio};
    end

    if (take)
    begin
      // RULE9: latch vector and level
      pending_next = {5'h00, newLevel, newVec};
      if (!inHandler_reg)
        savedLevel_next = cpuLevel;
      inHandler_next = 1'b1;
      // RULE21: raise CPU level
      // RULE19: top bit tracks level above 7
      topBit_next = newLevel[TOP_LEVEL_BIT];
      status_next[LEVEL_LSB +: PRIO_W] = newLevel[PRIO_W-1:0];
      irqRequest_next = 1'b1;
      irqVector_next = newVec;
      // RULE17: table select
      handlerAddr_next = (ctrlB_reg[ALT_SEL_BIT] ? ALT_TABLE_BASE : DEFAULT_TABLE_BASE)
                         + {16'h0000, newVec, 1'b0};
      if (newVec >= USER_VEC_BASE)
        flag_next[newVec - USER_VEC_BASE] = 1'b0 | hwSet[newVec - USER_VEC_BASE];
    end
  end

  ////////////////////////////////////////////////////////////////
  // RULE3: decodes 53 registers, where the rule names seventeen
  always_comb
  begin
    logic [15:0] rd;
    rd = '0;
    pslverr_next = 1'b0;
    pready_next = psel && !penable;
    prdata_next = prdata_reg;
    if (psel && !penable)
    begin
      if (regOff == CTRL_A_OFFSET)
        rd = ctrlA_reg;
      else if (regOff == CTRL_B_OFFSET)
        rd = ctrlB_reg;
      else if (regOff == PENDING_OFFSET)
        rd = pending_reg;
      else if (regOff == STATUS_WORD_OFFSET)
        rd = status_reg;
      else if (regOff == CORE_CTRL_OFFSET)
        // RULE12: top bit is read-only
        rd = {12'h000, topBit_reg, 3'b000};
      else if (regOff == RETURN_OFFSET || regOff == ACK_OFFSET)
        rd = '0;
      else if (regOff >= FLAG_BASE_OFFSET && regOff < ENABLE_BASE_OFFSET)
      begin
        for (int b = 0; b < 16; b++)
          if (16 * int'(regOff[11:2] - 10'h002) + b < NUM_REQ)
            rd[b] = flag_reg[16 * int'(regOff[11:2] - 10'h002) + b];
      end
      else if (regOff >= ENABLE_BASE_OFFSET && regOff < PRIO_BASE_OFFSET)
      begin
        for (int b = 0; b < 16; b++)
          if (16 * int'(regOff[11:2] - 10'h00a) + b < NUM_REQ)
            rd[b] = enable_reg[16 * int'(regOff[11:2] - 10'h00a) + b];
      end
      else if (regOff >= PRIO_BASE_OFFSET && regOff < PENDING_OFFSET)
      begin
        for (int s = 0; s < REQ_PER_PRIO; s++)
          if (REQ_PER_PRIO * int'(regOff[11:2] - 10'h012) + s < NUM_REQ)
            rd[4 * s +: PRIO_W] = prio_reg[(REQ_PER_PRIO * int'(regOff[11:2] - 10'h012) + s) * PRIO_W +: PRIO_W];
      end
      else
        pslverr_next = 1'b1;
      prdata_next = rdAccess ? {16'h0000, rd} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrlA_reg <= REG_RESET;
      ctrlB_reg <= REG_RESET;
      flag_reg <= '0;
      enable_reg <= '0;
      prio_reg <= {NUM_REQ{PRIO_RESET}};
      status_reg <= REG_RESET;
      topBit_reg <= 1'b0;
      pending_reg <= REG_RESET;
      savedLevel_reg <= '0;
      inHandler_reg <= 1'b0;
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      irqRequest_reg <= 1'b0;
      irqVector_reg <= '0;
      handlerAddr_reg <= '0;
    end
    else
    begin
      ctrlA_reg <= ctrlA_next;
      ctrlB_reg <= ctrlB_next;
      flag_reg <= flag_next;
      enable_reg <= enable_next;
      prio_reg <= prio_next;
      status_reg <= status_next;
      topBit_reg <= topBit_next;
      pending_reg <= pending_next;
      savedLevel_reg <= savedLevel_next;
      inHandler_reg <= inHandler_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      irqRequest_reg <= irqRequest_next;
      irqVector_reg <= irqVector_next;
      handlerAddr_reg <= handlerAddr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irqRequest = irqRequest_reg;
  assign irqVector = irqVector_reg;
  assign handlerAddr = handlerAddr_reg;

endmodule : vectored_priority_interrupt_ctrl
